// ### common/tick_pkg.sv
// Constants and register map of the tick counter block
package tick_pkg;

   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_TICK_COUNT    = 3'h1;
   localparam logic [2:0] IDX_SETUP         = 3'h2;
   localparam logic [2:0] IDX_PIN_DIRECTION = 3'h3;
   localparam logic [2:0] IDX_WDT_CLEAR     = 3'h4;
   localparam logic [2:0] IDX_STATUS        = 3'h5;

   // Setup word fields
   localparam int         SRC_SEL_BIT   = 5;
   localparam int         EDGE_SEL_BIT  = 4;
   localparam int         ASSIGN_BIT    = 3;
   localparam int         RATIO_LSB     = 0;
   localparam int         RATIO_W       = 3;

   // Status word fields
   localparam int         STAT_MODE_BIT    = 0;
   localparam int         STAT_ASSIGN_BIT  = 1;
   localparam int         STAT_INHIBIT_BIT = 2;

   // Values after reset
   localparam logic [7:0] SETUP_RST     = 8'hff;
   localparam logic [3:0] PIN_DIR_RST   = 4'hf;
   localparam logic [7:0] PRESCALE_RST  = 8'h00;

   // Pin shared with the count input
   localparam int         COUNT_PIN_BIT = 2;

   // Timing: one oscillator period per clock, four phases per instruction
   localparam int         CLKS_PER_INST    = 4;
   localparam logic [1:0] PHASE_Q2         = 2'h1;
   localparam logic [1:0] PHASE_Q4         = 2'h3;
   localparam int         INHIBIT_INST     = 2;
   localparam logic [3:0] INHIBIT_CLKS     = 4'(INHIBIT_INST * CLKS_PER_INST);

endpackage

// ### logic/phase_sampler.sv
// Samples a count level on the second and fourth phase of each instruction
`timescale 1ns/10ps
module phase_sampler
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic [1:0] i_phase,
   input  wire logic       i_level,
   output logic            o_rise
);
   import tick_pkg::*;

   typedef struct packed {
      logic smp;
      logic prev;
      logic fresh;
      logic seen;
      logic armed;
   } samp_s;

   samp_s st_r;
   samp_s st_nxt;

   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.fresh = 1'b0;
      if ((i_phase == PHASE_Q2) || (i_phase == PHASE_Q4))
      begin
         st_nxt.prev  = st_r.smp;
         st_nxt.smp   = i_level;
         st_nxt.fresh = 1'b1;
         st_nxt.seen  = 1'b1;
         st_nxt.armed = st_r.seen;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // Only one pulse per sampled rise, so a level held long never recounts
   // First sample after reset has no real predecessor, so no false edge
   assign o_rise = st_r.fresh & st_r.armed & st_r.smp & ~st_r.prev;

endmodule

// ### logic/tick_timer.sv
// Eight-bit timer/counter with shared prescaler and Avalon-MM registers
`timescale 1ns/10ps
module tick_timer
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [4:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [3:0]  i_byteenable,
   input  wire logic [31:0] i_writedata,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   input  wire logic        i_ext_count,
   input  wire logic        i_wdt_tick,
   output logic             o_wdt_clear,
   output logic             o_wdt_post,
   output logic      [3:0]  o_pin_dir
);
   import tick_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [1:0]  phase;
      logic [7:0]  setup;
      logic [3:0]  dir;
      logic [3:0]  pin_dir;
      logic [7:0]  pre;
      logic [3:0]  inhibit;
      logic        ext_prev;
      logic        rise_d;
      logic [7:0]  count;
      logic        waitreq;
      logic [31:0] rdata;
      logic        wdt_clr;
      logic        wdt_post;
   } tmr_s;

   localparam tmr_s ST_RST = '{
      phase:    2'h0,
      setup:    SETUP_RST,
      dir:      PIN_DIR_RST,
      pin_dir:  PIN_DIR_RST,
      pre:      PRESCALE_RST,
      inhibit:  4'h0,
      ext_prev: 1'b0,
      rise_d:   1'b0,
      count:    8'h00,
      waitreq:  1'b1,
      rdata:    32'h0000_0000,
      wdt_clr:  1'b0,
      wdt_post: 1'b0
   };

   tmr_s                   st_r;
   tmr_s                   st_nxt;

   logic                   count_mode;
   logic                   edge_fall;
   logic                   wdt_assign;
   logic [RATIO_W-1:0]     ratio;
   logic                   inst_tick;
   logic                   ext_level;
   logic                   ext_rise;
   logic [7:0]             cnt_mask;
   logic [7:0]             wdt_mask;
   logic                   pre_evt;
   logic                   samp_level;
   logic                   samp_rise;
   logic                   inc;
   logic                   req;
   logic                   addr_ok;
   logic [2:0]             idx;
   logic                   wr_low;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded setup and count sources

   always_comb
   begin
      count_mode = st_r.setup[SRC_SEL_BIT];
      edge_fall  = st_r.setup[EDGE_SEL_BIT];
      wdt_assign = st_r.setup[ASSIGN_BIT];
      ratio      = st_r.setup[RATIO_LSB +: RATIO_W];
      inst_tick  = (st_r.phase == PHASE_Q4);
      // Falling edge counting is rising edge counting of the inverted pin
      ext_level  = i_ext_count ^ edge_fall;
      ext_rise   = ext_level & ~st_r.ext_prev;
      cnt_mask   = 8'((9'h002 << ratio) - 9'h001);
      wdt_mask   = 8'((9'h001 << ratio) - 9'h001);
      if (wdt_assign)
         pre_evt = i_wdt_tick;
      else if (count_mode)
         pre_evt = ext_rise;
      else
         pre_evt = inst_tick;
      // Without the prescaler the edge-selected pin goes to the sampler
      samp_level = wdt_assign ? ext_level : st_r.pre[ratio];
   end

   phase_sampler u_sampler
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_phase   (st_r.phase),
      .i_level   (samp_level),
      .o_rise    (samp_rise)
   );

   always_comb
   begin
      if (count_mode)
         inc = st_r.rise_d;
      else if (wdt_assign)
         inc = inst_tick;
      else
         inc = inst_tick && ((st_r.pre & cnt_mask) == cnt_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   always_comb
   begin
      req     = i_read | i_write;
      idx     = i_address[4:2];
      addr_ok = (i_address[1:0] == 2'b00);
      wr_low  = i_write & i_byteenable[0] & addr_ok;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.phase    = st_r.phase + 2'h1;
      st_nxt.ext_prev = ext_level;
      // Extra stage keeps pin-to-count delay at three clocks or more
      st_nxt.rise_d   = samp_rise;
      st_nxt.wdt_clr  = 1'b0;
      st_nxt.wdt_post = 1'b0;

      // Prescaler advances on its assigned source
      if (pre_evt)
         st_nxt.pre = st_r.pre + 8'h01;
      if (wdt_assign && i_wdt_tick && ((st_r.pre & wdt_mask) == wdt_mask))
         st_nxt.wdt_post = 1'b1;

      // Counter increments, held off after a software write
      if (st_r.inhibit != 4'h0)
         st_nxt.inhibit = st_r.inhibit - 4'h1;
      else if (inc)
         st_nxt.count = st_r.count + 8'h01;

      // Read data captured on the first request cycle
      if (req && st_r.waitreq)
      begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata   = 32'h0000_0000;
         if (i_read && addr_ok)
         begin
            // Prescaler has no read path at all
            if (idx == IDX_TICK_COUNT)
               st_nxt.rdata = {24'h00_0000, st_r.count};
            else if (idx == IDX_STATUS)
               st_nxt.rdata = {29'h0, (st_r.inhibit != 4'h0), wdt_assign, count_mode};
         end
      end
      else
         st_nxt.waitreq = 1'b1;

      // Writes take effect on the cycle waitrequest is low
      if (req && !st_r.waitreq && wr_low)
      begin
         if (idx == IDX_TICK_COUNT)
         begin
            // Write wins over a same-cycle increment
            st_nxt.count   = i_writedata[7:0];
            st_nxt.inhibit = INHIBIT_CLKS;
            if (!wdt_assign)
               st_nxt.pre = PRESCALE_RST;
         end
         else if (idx == IDX_SETUP)
            st_nxt.setup = i_writedata[7:0];
         else if (idx == IDX_PIN_DIRECTION)
            st_nxt.dir = i_writedata[3:0];
         else if (idx == IDX_WDT_CLEAR)
         begin
            st_nxt.wdt_clr = 1'b1;
            if (wdt_assign)
               st_nxt.pre = PRESCALE_RST;
         end
      end

      // Count mode overrides the pin's direction bit
      st_nxt.pin_dir = st_nxt.dir;
      if (st_nxt.setup[SRC_SEL_BIT])
         st_nxt.pin_dir[COUNT_PIN_BIT] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         st_r       <= ST_RST;
         // Counter value survives resets; undefined only at power-on
         st_r.count <= st_r.count;
      end
      else
         st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_readdata    = st_r.rdata;
   assign o_waitrequest = st_r.waitreq;
   assign o_wdt_clear   = st_r.wdt_clr;
   assign o_wdt_post    = st_r.wdt_post;
   assign o_pin_dir     = st_r.pin_dir;

endmodule

// ### test/tick_timer_checker.sv
// Port-level checks for the tick timer
`timescale 1ns/10ps
module tick_timer_checker
(
   input wire logic        i_ref_clk,
   input wire logic        i_rst_n,
   input wire logic [4:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [3:0]  i_byteenable,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic        o_wdt_clear,
   input wire logic        o_wdt_post,
   input wire logic [3:0]  o_pin_dir
);
   logic [7:0] setup_r;
   logic       acc_w;
   assign acc_w = i_write && !o_waitrequest && i_byteenable[0];
   // Shadow of the setup word, which cannot be read back
   always_ff @(posedge i_ref_clk)
      if (!i_rst_n)
         setup_r <= 8'hff;
      else if (acc_w && i_address == 5'h08)
         setup_r <= i_writedata[7:0];
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////
   a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
      else $error("waitrequest not low for one cycle");
   a_wait_idle: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
      else $error("waitrequest dropped without request");
   a_rd_hold: assert property (!$past((i_read || i_write) && o_waitrequest) |-> $stable(o_readdata))
      else $error("read data moved without request");
   a_bad_read: assert property (i_read && o_waitrequest && !(i_address inside {5'h04, 5'h14}) |=> o_readdata == 0)
      else $error("hidden or unmapped place read nonzero");
   a_pin_force: assert property (setup_r[5] && $past(setup_r[5]) |-> o_pin_dir[2])
      else $error("count pin not forced to input");
   a_clr_pulse: assert property (o_wdt_clear == $past(acc_w && i_address == 5'h10))
      else $error("watchdog clear pulse wrong");
   a_post_route: assert property (o_wdt_post |-> setup_r[3] || $past(setup_r[3]))
      else $error("watchdog tick while prescaler on counter");
   a_rst_vals: assert property ($rose(i_rst_n) |-> o_waitrequest && o_pin_dir == 4'hf && !o_wdt_post)
      else $error("outputs wrong after reset");
   c_ext_mode: cover property (setup_r[5] && o_pin_dir[2]);
   c_clear: cover property (o_wdt_clear);
   c_post: cover property (o_wdt_post);
endmodule
bind tick_timer tick_timer_checker tick_timer_checker_i (.*);

// ### test/count_source.sv
// Model of the external source on the count pin
`timescale 1ns/10ps
module count_source
(
   input  wire logic i_ref_clk,
   output logic      o_level
);
   initial o_level = 1'b0;
   // Level held between toggles; two clocks is the shortest legal hold
   task automatic toggle(input int n, input int hold);
      repeat (n)
      begin
         repeat (hold) @(posedge i_ref_clk);
         o_level <= ~o_level;
      end
      repeat (hold) @(posedge i_ref_clk);
   endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the tick timer
`timescale 1ns/10ps
module tb;
   logic        clk, rst_n, rd, wr, tick;
   logic        ext, wreq, wclr, post;
   logic [4:0]  addr;
   logic [3:0]  be, pdir;
   logic [31:0] wdata, rdata;
   logic [7:0]  a, b;
   int          err_total = 0;
   int          num_checks = 0;
   int          posts = 0;
   tick_timer tick_timer_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd), .i_write(wr),
      .i_byteenable(be), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(wreq), .i_ext_count(ext),
      .i_wdt_tick(tick), .o_wdt_clear(wclr), .o_wdt_post(post), .o_pin_dir(pdir));
   count_source count_source_i (.i_ref_clk(clk), .o_level(ext));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
      if (post)
         posts++;
   ////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One request, held until waitrequest is seen low
   task automatic bus(input logic [4:0] ad, input logic w, input logic [7:0] d, output logic [7:0] q);
      addr <= ad;
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wreq !== 1'b0)
         @(posedge clk);
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input int n);
      repeat (n)
      begin
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         cyc(3);
      end
   endtask
   ////////////////////////////////////////
   task automatic t_timer;
      bus(5'h08, 1'b1, 8'h08, a);
      bus(5'h0c, 1'b1, 8'h00, a);
      bus(5'h04, 1'b1, 8'hf8, a);
      bus(5'h04, 1'b0, 8'h00, a);
      chk("inhibit", 8'hf8, a);
      chk("pin dir", 8'h00, {4'h0, pdir});
      cyc(10);
      bus(5'h04, 1'b0, 8'h00, a);
      cyc(37);
      bus(5'h04, 1'b0, 8'h00, b);
      chk("timer wrap", a + 8'h0a, b);
   endtask
   task automatic t_scale;
      for (int n = 0; n < 8; n++)
      begin
         bus(5'h08, 1'b1, 8'(n), a);
         bus(5'h04, 1'b1, 8'h00, a);
         cyc((8 << n) - 10);
         bus(5'h04, 1'b0, 8'h00, a);
         chk("prescale clear", 8'h00, a);
         cyc((32 << n) - 3);
         bus(5'h04, 1'b0, 8'h00, b);
         // At 1:2 the first prescaled increment falls inside the write inhibit
         chk("prescale", (n == 0) ? 8'h03 : 8'h04, b);
      end
   endtask
   task automatic t_count;
      bus(5'h08, 1'b1, 8'h28, a);
      bus(5'h04, 1'b1, 8'h00, a);
      cyc(8);
      chk("pin dir", 8'h04, {4'h0, pdir});
      count_source_i.toggle(9, 2);
      cyc(5);
      bus(5'h04, 1'b0, 8'h00, a);
      chk("rising", 8'h05, a);
      bus(5'h14, 1'b0, 8'h00, a);
      chk("status", 8'h03, a);
      bus(5'h08, 1'b1, 8'h38, a);
      bus(5'h04, 1'b1, 8'h00, a);
      cyc(8);
      count_source_i.toggle(7, 2);
      cyc(5);
      bus(5'h04, 1'b0, 8'h00, a);
      chk("falling", 8'h04, a);
      bus(5'h08, 1'b1, 8'h20, a);
      bus(5'h04, 1'b1, 8'h00, a);
      cyc(8);
      count_source_i.toggle(8, 2);
      cyc(5);
      bus(5'h04, 1'b0, 8'h00, a);
      chk("pin prescale", 8'h02, a);
   endtask
   task automatic t_wdt;
      int p;
      bus(5'h08, 1'b1, 8'h00, a);
      p = posts;
      pulse(4);
      chk("no post", 8'(p), 8'(posts));
      bus(5'h10, 1'b1, 8'h00, a);
      bus(5'h04, 1'b1, 8'h00, a);
      bus(5'h10, 1'b1, 8'h00, a);
      bus(5'h08, 1'b1, 8'h0a, a);
      pulse(3);
      bus(5'h10, 1'b1, 8'h00, a);
      p = posts;
      pulse(3);
      chk("post cleared", 8'(p), 8'(posts));
      pulse(1);
      chk("post", 8'(p + 1), 8'(posts));
      bus(5'h10, 1'b1, 8'h00, a);
      bus(5'h08, 1'b1, 8'h00, a);
   endtask
   task automatic t_regs;
      logic [4:0] bad [7] = '{5'h00, 5'h05, 5'h08, 5'h0c, 5'h10, 5'h18, 5'h1c};
      foreach (bad[i])
      begin
         bus(bad[i], 1'b0, 8'h00, a);
         chk("hidden read", 8'h00, a);
      end
      bus(5'h08, 1'b1, 8'h28, a);
      count_source_i.toggle(2, 2);
      bus(5'h04, 1'b1, 8'h5a, a);
      be <= 4'h0;
      bus(5'h04, 1'b1, 8'h11, a);
      be <= 4'h1;
      rst_n <= 1'b0;
      cyc(2);
      chk("reset dir", 8'h0f, {4'h0, pdir});
      rst_n <= 1'b1;
      cyc(8);
      bus(5'h04, 1'b0, 8'h00, a);
      chk("kept count", 8'h5a, a);
      bus(5'h14, 1'b0, 8'h00, a);
      chk("reset setup", 8'h03, a);
   endtask
   task automatic complete_run;
      $display("Checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      tick = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      be = 4'h1;
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      t_timer();
      t_scale();
      t_count();
      t_wdt();
      t_regs();
      complete_run();
   end
   initial
   begin
      cyc(30000);
      err_total++;
      complete_run();
   end
endmodule
